// ### src/uie_pkg.sv
// uart interrupt enable and status block: shared constants
// assumes a parallel 8-bit register bus with a 3-bit address
`default_nettype none
package uie_pkg;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR_FCR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_EFR = 3'h2;
  localparam logic [2:0] ADDR_FLOW_RESUME_CHAR_ONE = 3'h4;
  localparam logic [2:0] ADDR_FLOW_RESUME_CHAR_TWO = 3'h5;
  localparam logic [2:0] ADDR_FLOW_PAUSE_CHAR_ONE = 3'h6;
  localparam logic [2:0] ADDR_FLOW_PAUSE_CHAR_TWO = 3'h7;
  localparam logic [7:0] LCR_ENHANCED = 8'hBF;
  localparam int LCR_DLAB_BIT = 7;
  localparam int EFR_UNLOCK_BIT = 4;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] IER_UNLOCK_MASK = 8'hF0;
  localparam logic [7:0] MCR_UNLOCK_MASK = 8'hE0;
  localparam logic [7:0] FCR_UNLOCK_MASK = 8'h30;
  localparam logic [5:0] ISR_LINE = 6'h06;
  localparam logic [5:0] ISR_RXTO = 6'h0C;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_TXRDY = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
endpackage
`default_nettype wire

// ### src/uie_rise_det.sv
// rising edge detector for an asynchronous level, two-stage synchronised
// assumes one clock, asynchronous active-high reset
`default_nettype none
module uie_rise_det (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in, pulse out
  input wire logic level_in,
  output logic rise_out
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // idle level of an active-low pin, so no false edge follows reset
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_out = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// ### src/uie_top.sv
// uart channel interrupt enable, interrupt status and line status logic
// assumes the fifos, shift registers and modem pins sit outside this block
// and report their levels and events on the same clock, except the pins
//
// Overview of operation
// RL1: with fifo and receive enable on, rx interrupt follows fill at or above trigger
// RL2: rx code shows in status register while fill meets trigger, clears below
// RL3: data-ready status bit 0 set while receive fifo holds a character
// RL4: host may poll with fifo enabled and enable bits 0 to 3 clear
// RL5: status bit 1 flags a receive overrun
// RL6: status bits 2 to 4 give parity, framing, break of head character
// RL7: bit 5 while tx fifo empty; bit 6 while fifo and shifter empty
// RL8: bit 7 set when any character in receive fifo carries an error
// RL9: enable bit 0: rx interrupt on holding char or fifo trigger level
// RL10: enable bit 1: tx interrupt on fifo empty, also at once if empty
// RL11: enable bit 2: line interrupt when any of status bits 1 to 4 gets set, held until status read
// RL12: overrun interrupts on reception; other errors when errored char reaches the head
// RL13: enable bit 3 gates modem interrupt, reset default off
// RL14: enable bit 4 permits sleep, writable only when unlocked, default off
// RL15: enable bit 5 gates pause character interrupt, needs unlock
// RL16: enable bit 6 with unlock: interrupt on request-to-send rising
// RL17: enable bit 7 with unlock: interrupt on clear-to-send rising
// RL18: feature bit 4 unlocks upper enable, status, fifo and modem bits
// RL19: all enable bits reset to zero
// RL20: masked sources not reported; enabled ones shown in status register (a latched pin edge interrupt stays reported after bits 6 and 7 clear)
// RL21: trigger level selectable 1, 4, 8 or 14 characters
// RL22: status bit 0 reads one when nothing pending, zero otherwise
// RL23: interrupt output high while any enabled source pending
`default_nettype none
module uie_top
  import uie_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // host register bus
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  // receive path status
  input wire logic [4:0] RX_LEVEL,
  input wire logic RX_PUSH,
  input wire logic RX_OVERRUN,
  input wire logic [2:0] RX_HEAD_ERR,
  input wire logic RX_ANY_ERR,
  input wire logic RX_TIMEOUT,
  input wire logic RX_HOLD_FULL,
  input wire logic RX_PAUSE_SEEN,
  input wire logic RX_RESUME_SEEN,
  // transmit path status
  input wire logic TX_FIFO_EMPTY,
  input wire logic TX_SHIFT_EMPTY,
  // modem side
  input wire logic MODEM_DELTA,
  input wire logic RTS_PIN_N,
  input wire logic CTS_PIN_N,
  // outputs to channel
  output logic INT_OUT,
  output logic SLEEP_EN,
  output logic FIFO_EN,
  output logic RX_FIFO_CLR,
  output logic TX_FIFO_CLR,
  output logic [7:0] FLOW_CTRL,
  output logic [7:0] MODEM_CTRL,
  output logic [7:0] LINE_CTRL
);
  // ==========================================================
  // register state
  logic [7:0] ier_reg;
  logic [7:0] efr_reg;
  logic [7:0] lcr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] fcr_reg;
  logic [7:0] flow_resume_char_one_reg;
  logic [7:0] flow_resume_char_two_reg;
  logic [7:0] flow_pause_char_one_reg;
  logic [7:0] flow_pause_char_two_reg;
  logic overrun_reg;
  logic line_int_reg;
  logic tx_int_reg;
  logic pause_int_reg;
  logic flow_int_reg;
  logic modem_int_reg;
  logic [7:0] rdata_reg;
  logic int_reg;
  logic rx_clr_reg;
  logic tx_clr_reg;
  logic sleep_reg;
  logic [7:0] mcr_out_reg;
  logic tx_empty_last_reg;
  logic [2:0] head_err_last_reg;

  // ==========================================================
  // address decode
  wire enh_sel = (lcr_reg == LCR_ENHANCED);
  wire dlab = lcr_reg[LCR_DLAB_BIT];
  wire unlocked = efr_reg[EFR_UNLOCK_BIT];
  wire wr_ier = WR_STB && !dlab && ADDR == ADDR_IER;
  wire wr_fcr = WR_STB && !enh_sel && ADDR == ADDR_ISR_FCR;
  wire wr_lcr = WR_STB && ADDR == ADDR_LCR;
  wire wr_mcr = WR_STB && !enh_sel && ADDR == ADDR_MCR;
  wire wr_efr = WR_STB && enh_sel && ADDR == ADDR_EFR;
  wire wr_flow_resume_char_one = WR_STB && enh_sel && ADDR == ADDR_FLOW_RESUME_CHAR_ONE;
  wire wr_flow_resume_char_two = WR_STB && enh_sel && ADDR == ADDR_FLOW_RESUME_CHAR_TWO;
  wire wr_flow_pause_char_one = WR_STB && enh_sel && ADDR == ADDR_FLOW_PAUSE_CHAR_ONE;
  wire wr_flow_pause_char_two = WR_STB && enh_sel && ADDR == ADDR_FLOW_PAUSE_CHAR_TWO;
  wire rd_isr = RD_STB && !enh_sel && ADDR == ADDR_ISR_FCR;
  wire rd_lsr = RD_STB && !enh_sel && ADDR == ADDR_LSR;
  wire rd_msr = RD_STB && !enh_sel && ADDR == ADDR_MSR;

  // locked bits keep their stored value, which is zero unless unlocked earlier
  function automatic logic [7:0] lock_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask, input logic unl);
    lock_merge = unl ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  wire [7:0] ier_next = lock_merge(ier_reg, WDATA, IER_UNLOCK_MASK, unlocked); // RL14 RL18
  wire [7:0] mcr_next = lock_merge(mcr_reg, WDATA, MCR_UNLOCK_MASK, unlocked); // RL18
  wire [7:0] fcr_next = lock_merge(fcr_reg, WDATA, FCR_UNLOCK_MASK, unlocked); // RL18

  // upper bits act only while unlocked
  wire [7:0] ier_eff = unlocked ? ier_reg : (ier_reg & ~IER_UNLOCK_MASK); // RL18
  wire [7:0] mcr_eff = unlocked ? mcr_reg : (mcr_reg & ~MCR_UNLOCK_MASK); // RL18

  // ==========================================================
  // trigger level and receive sources
  wire [4:0] trig_level = (fcr_reg[7:6] == 2'b00) ? TRIG_1 :
                          (fcr_reg[7:6] == 2'b01) ? TRIG_4 :
                          (fcr_reg[7:6] == 2'b10) ? TRIG_8 : TRIG_14; // RL21
  wire fifo_mode = fcr_reg[FCR_EN_BIT];
  wire rx_avail = fifo_mode ? (RX_LEVEL >= trig_level) : RX_HOLD_FULL; // RL1 RL9
  wire data_ready = fifo_mode ? (RX_LEVEL != 5'h00) : RX_HOLD_FULL; // RL3

  // ==========================================================
  // line status assembly
  wire [7:0] lsr_val = {RX_ANY_ERR & fifo_mode, // RL8
                        TX_FIFO_EMPTY & TX_SHIFT_EMPTY, // RL7
                        TX_FIFO_EMPTY, // RL7
                        RX_HEAD_ERR, // RL6
                        overrun_reg, // RL5
                        data_ready}; // RL3

  // errors on a character newly at the head, i.e. reached by reading out
  wire head_err_new = |(RX_HEAD_ERR & ~head_err_last_reg); // RL12
  wire tx_empty_rise = TX_FIFO_EMPTY & ~tx_empty_last_reg;
  wire ier1_set = wr_ier && WDATA[1] && !ier_reg[1];
  wire rts_rise;
  wire cts_rise;

  // ==========================================================
  // enabled pending sources and priority
  wire src_line = ier_eff[2] & line_int_reg; // RL11 RL20
  wire src_rxto = ier_eff[0] & fifo_mode & RX_TIMEOUT;
  wire src_rx = ier_eff[0] & rx_avail; // RL1 RL9 RL20
  wire src_tx = ier_eff[1] & tx_int_reg; // RL10 RL20
  wire src_modem = ier_eff[3] & modem_int_reg; // RL13 RL20
  wire src_pause = ier_eff[5] & pause_int_reg; // RL15
  wire src_flow = flow_int_reg; // RL16 RL17
  wire any_pending = src_line | src_rxto | src_rx | src_tx | src_modem | src_pause | src_flow;

  wire [5:0] isr_code = src_line ? ISR_LINE :
                        src_rxto ? ISR_RXTO :
                        src_rx ? ISR_RXRDY : // RL2
                        src_tx ? ISR_TXRDY :
                        src_modem ? ISR_MODEM :
                        src_pause ? ISR_XOFF :
                        src_flow ? ISR_FLOW : ISR_NONE; // RL22
  wire [7:0] isr_val = {fifo_mode, fifo_mode, isr_code};

  // ==========================================================
  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = REG_RESET;
    if (enh_sel) begin
      unique case (ADDR)
        ADDR_EFR: rd_mux = efr_reg;
        ADDR_FLOW_RESUME_CHAR_ONE: rd_mux = flow_resume_char_one_reg;
        ADDR_FLOW_RESUME_CHAR_TWO: rd_mux = flow_resume_char_two_reg;
        ADDR_FLOW_PAUSE_CHAR_ONE: rd_mux = flow_pause_char_one_reg;
        ADDR_FLOW_PAUSE_CHAR_TWO: rd_mux = flow_pause_char_two_reg;
        ADDR_LCR: rd_mux = lcr_reg;
        default: rd_mux = REG_RESET;
      endcase
    end else begin
      unique case (ADDR)
        ADDR_IER: rd_mux = dlab ? REG_RESET : ier_eff;
        ADDR_ISR_FCR: rd_mux = isr_val;
        ADDR_LCR: rd_mux = lcr_reg;
        ADDR_MCR: rd_mux = mcr_eff;
        ADDR_LSR: rd_mux = lsr_val;
        default: rd_mux = REG_RESET;
      endcase
    end
  end

  // ==========================================================
  // pin edge detection
  uie_rise_det u_rts (
    .clk(CLK),
    .rst(RST),
    .level_in(RTS_PIN_N),
    .rise_out(rts_rise)
  );
  uie_rise_det u_cts (
    .clk(CLK),
    .rst(RST),
    .level_in(CTS_PIN_N),
    .rise_out(cts_rise)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ier_reg <= REG_RESET; // RL19
      efr_reg <= REG_RESET;
      lcr_reg <= REG_RESET;
      mcr_reg <= REG_RESET;
      fcr_reg <= REG_RESET;
      flow_resume_char_one_reg <= REG_RESET;
      flow_resume_char_two_reg <= REG_RESET;
      flow_pause_char_one_reg <= REG_RESET;
      flow_pause_char_two_reg <= REG_RESET;
    end else begin
      if (wr_ier) ier_reg <= ier_next;
      if (wr_efr) efr_reg <= WDATA;
      if (wr_lcr) lcr_reg <= WDATA;
      if (wr_mcr) mcr_reg <= mcr_next;
      if (wr_fcr) fcr_reg <= WDATA[FCR_EN_BIT] ? fcr_next : REG_RESET;
      if (wr_flow_resume_char_one) flow_resume_char_one_reg <= WDATA;
      if (wr_flow_resume_char_two) flow_resume_char_two_reg <= WDATA;
      if (wr_flow_pause_char_one) flow_pause_char_one_reg <= WDATA;
      if (wr_flow_pause_char_two) flow_pause_char_two_reg <= WDATA;
    end
  end

  // ==========================================================
  // sticky interrupt sources; a set wins over a clear in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      overrun_reg <= 1'b0;
      line_int_reg <= 1'b0;
      tx_int_reg <= 1'b0;
      pause_int_reg <= 1'b0;
      flow_int_reg <= 1'b0;
      modem_int_reg <= 1'b0;
      tx_empty_last_reg <= 1'b0;
      head_err_last_reg <= 3'h0;
    end else begin
      tx_empty_last_reg <= TX_FIFO_EMPTY;
      head_err_last_reg <= RX_HEAD_ERR;
      if (RX_OVERRUN) overrun_reg <= 1'b1; // RL5
      else if (rd_lsr) overrun_reg <= 1'b0;
      if (RX_OVERRUN || head_err_new) line_int_reg <= 1'b1; // RL11 RL12
      else if (rd_lsr) line_int_reg <= 1'b0;
      if (tx_empty_rise || (ier1_set && TX_FIFO_EMPTY)) tx_int_reg <= 1'b1; // RL10
      else if (rd_isr || !TX_FIFO_EMPTY) tx_int_reg <= 1'b0;
      if (RX_PAUSE_SEEN) pause_int_reg <= 1'b1; // RL15
      else if (rd_isr || RX_RESUME_SEEN) pause_int_reg <= 1'b0;
      if ((rts_rise && ier_eff[6]) || (cts_rise && ier_eff[7])) flow_int_reg <= 1'b1; // RL16 RL17
      else if (rd_msr) flow_int_reg <= 1'b0;
      if (MODEM_DELTA) modem_int_reg <= 1'b1; // RL13
      else if (rd_msr) modem_int_reg <= 1'b0;
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= REG_RESET;
      int_reg <= 1'b0;
      rx_clr_reg <= 1'b0;
      tx_clr_reg <= 1'b0;
      sleep_reg <= 1'b0;
      mcr_out_reg <= REG_RESET;
    end else begin
      sleep_reg <= ier_eff[4]; // RL14
      mcr_out_reg <= mcr_eff; // RL18
      rdata_reg <= RD_STB ? rd_mux : REG_RESET;
      int_reg <= any_pending; // RL23
      rx_clr_reg <= wr_fcr && WDATA[FCR_EN_BIT] && WDATA[FCR_RXRST_BIT];
      tx_clr_reg <= wr_fcr && WDATA[FCR_EN_BIT] && WDATA[FCR_TXRST_BIT];
    end
  end

  assign RDATA = rdata_reg;
  assign INT_OUT = int_reg;
  assign SLEEP_EN = sleep_reg; // RL14
  assign FIFO_EN = fcr_reg[FCR_EN_BIT]; // RL4
  assign RX_FIFO_CLR = rx_clr_reg;
  assign TX_FIFO_CLR = tx_clr_reg;
  assign FLOW_CTRL = efr_reg;
  assign MODEM_CTRL = mcr_out_reg;
  assign LINE_CTRL = lcr_reg;
endmodule
`default_nettype wire

// ### testbench/uie_host_model.sv
// host side of the register bus: one strobe per access, driven at the falling edge
// assumes the block takes strobes at the rising edge and answers one cycle later
`default_nettype none
module uie_host_model (
  // clock
  input wire logic clk,
  // register bus
  output logic [2:0] addr,
  output logic [7:0] wdata,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // released write data is inverted so a stale value never passes
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr_stb = 1'b1;
    @(negedge clk);
    wr_stb = 1'b0;
    wdata = ~v;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd_stb = 1'b1;
    @(negedge clk);
    rd_stb = 1'b0;
    v = rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/uie_top_monitor.sv
// checker of the interrupt enable and status block
// assumes a bind to uie_top; sees only its ports
`default_nettype none
module uie_monitor
  import uie_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register bus
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] RDATA,
  // channel status
  input wire logic [4:0] RX_LEVEL,
  input wire logic [2:0] RX_HEAD_ERR,
  input wire logic RX_ANY_ERR,
  input wire logic TX_FIFO_EMPTY,
  input wire logic TX_SHIFT_EMPTY,
  // outputs
  input wire logic INT_OUT,
  input wire logic SLEEP_EN,
  input wire logic FIFO_EN,
  input wire logic [7:0] MODEM_CTRL,
  input wire logic [7:0] FLOW_CTRL,
  input wire logic [7:0] LINE_CTRL
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // helpers
  wire logic lsr_rd = RD_STB && ADDR == ADDR_LSR && LINE_CTRL != LCR_ENHANCED && FIFO_EN;
  wire logic unl = FLOW_CTRL[EFR_UNLOCK_BIT];
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ====================
  // assertions
  reset_quiet_a: assert property ($fell(RST) |-> !INT_OUT && !SLEEP_EN)
    else $error("output active after reset");
  lsr_ready_a: assert property (lsr_rd |=> RDATA[0] == ($past(RX_LEVEL) != 5'h00))
    else $error("data ready bit wrong");
  lsr_error_a: assert property (lsr_rd |=> RDATA[4:2] == $past(RX_HEAD_ERR))
    else $error("error bits wrong");
  lsr_tx_a: assert property (lsr_rd |=>
    RDATA[6:5] == {$past(TX_SHIFT_EMPTY) && $past(TX_FIFO_EMPTY), $past(TX_FIFO_EMPTY)})
    else $error("transmit empty bits wrong");
  lsr_global_a: assert property (lsr_rd |=> RDATA[7] == $past(RX_ANY_ERR))
    else $error("global error bit wrong");
  tx_enable_a: assert property (WR_STB && ADDR == ADDR_IER && LINE_CTRL == 8'h00
    && WDATA[1] && TX_FIFO_EMPTY ##1 TX_FIFO_EMPTY && !RD_STB |=> INT_OUT)
    else $error("no interrupt on enable with empty fifo");
  sleep_lock_a: assert property (!unl ##1 !unl |-> !SLEEP_EN)
    else $error("sleep enabled while locked");
  modem_lock_a: assert property (!unl ##1 !unl |-> MODEM_CTRL[7:5] == 3'h0)
    else $error("upper modem bits active while locked");
endmodule
bind uie_top uie_monitor uie_monitor_inst (.CLK, .RST, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
  .RX_LEVEL, .RX_HEAD_ERR, .RX_ANY_ERR, .TX_FIFO_EMPTY, .TX_SHIFT_EMPTY, .INT_OUT, .SLEEP_EN,
  .FIFO_EN, .MODEM_CTRL, .FLOW_CTRL, .LINE_CTRL);
`default_nettype wire

// ### testbench/uie_top_test.sv
// self-checking bench of the interrupt enable and status block
// assumes uie_top, the host model and the bound checker are compiled before it
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module uie_top_test
  import uie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  int failures = 0;
  int n_tests = 0;
  int trig [4] = '{1, 4, 8, 14};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d, ex;
  logic wr_stb, rd_stb, int_out, sleep_en, fifo_en;
  logic [4:0] rx_level = 5'h00;
  logic [2:0] rx_head_err = 3'h0;
  logic [2:0] ev = 3'h0;
  logic rx_any_err = 1'b0, tx_empty = 1'b0, shift_empty = 1'b0;
  logic [1:0] pin_n = 2'h3;
  always #10 clk = ~clk;
  // ====================
  // design and host
  uie_top uie_top_inst (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .RX_LEVEL(rx_level), .RX_PUSH(1'b0), .RX_OVERRUN(ev[0]),
    .RX_HEAD_ERR(rx_head_err), .RX_ANY_ERR(rx_any_err), .RX_TIMEOUT(1'b0), .RX_HOLD_FULL(1'b0),
    .RX_PAUSE_SEEN(ev[2]), .RX_RESUME_SEEN(1'b0), .TX_FIFO_EMPTY(tx_empty),
    .TX_SHIFT_EMPTY(shift_empty), .MODEM_DELTA(ev[1]), .RTS_PIN_N(pin_n[0]),
    .CTS_PIN_N(pin_n[1]), .INT_OUT(int_out), .SLEEP_EN(sleep_en), .FIFO_EN(fifo_en),
    .RX_FIFO_CLR(), .TX_FIFO_CLR(), .FLOW_CTRL(), .MODEM_CTRL(), .LINE_CTRL());
  uie_host_model uie_host_model_inst (.clk(clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata));
  // ====================
  // tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    uie_host_model_inst.wr(a, v);
  endtask
  task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
    uie_host_model_inst.rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(input int b);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask
  task automatic int_chk(input logic e);
    settle(3);
    `CHK("interrupt", e, int_out)
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    complete_run;
  end
  // ====================
  // scenarios
  initial begin
    void'($urandom(105));
    settle(6);
    rst = 1'b0;
    rd_chk("enable", ADDR_IER, REG_RESET);
    rd_chk("status", ADDR_ISR_FCR, {2'b00, ISR_NONE});
    wr(ADDR_IER, 8'hFF);
    rd_chk("locked", ADDR_IER, 8'h0F);
    `CHK("sleep", 1'b0, sleep_en)
    wr(ADDR_LCR, LCR_ENHANCED);
    wr(ADDR_EFR, 8'h10);
    wr(ADDR_LCR, 8'h00);
    wr(ADDR_IER, 8'hFF);
    rd_chk("unlocked", ADDR_IER, 8'hFF);
    `CHK("sleep", 1'b1, sleep_en)
    wr(ADDR_IER, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ISR_FCR, {i[1:0], 6'h01});
      rx_level = 5'(trig[i]);
      int_chk(1'b0);
      rd_chk("masked", ADDR_ISR_FCR, {2'b11, ISR_NONE});
      `CHK("fifo", 1'b1, fifo_en)
      wr(ADDR_IER, 8'h01);
      rx_level = 5'(trig[i] - 1);
      int_chk(1'b0);
      rx_level = 5'(trig[i]);
      int_chk(1'b1);
      rd_chk("rx code", ADDR_ISR_FCR, {2'b11, ISR_RXRDY});
      rx_level = 5'(trig[i] - 1);
      int_chk(1'b0);
      rd_chk("rx gone", ADDR_ISR_FCR, {2'b11, ISR_NONE});
      wr(ADDR_IER, 8'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rx_level = 5'($urandom_range(16));
      rx_head_err = 3'($urandom);
      {rx_any_err, tx_empty, shift_empty} = 3'($urandom);
      settle(2);
      ex = {rx_any_err, tx_empty & shift_empty, tx_empty, rx_head_err, 1'b0, rx_level != 5'h00};
      rd_chk("line status", ADDR_LSR, ex);
    end
    {rx_level, rx_head_err, rx_any_err, tx_empty, shift_empty} = 11'h001;
    wr(ADDR_IER, 8'h02);
    int_chk(1'b0);
    tx_empty = 1'b1;
    int_chk(1'b1);
    rd_chk("tx code", ADDR_ISR_FCR, {2'b11, ISR_TXRDY});
    int_chk(1'b0);
    wr(ADDR_IER, 8'h00);
    wr(ADDR_IER, 8'h02);
    int_chk(1'b1);
    wr(ADDR_IER, 8'h04);
    int_chk(1'b0);
    pulse(0);
    int_chk(1'b1);
    rd_chk("line code", ADDR_ISR_FCR, {2'b11, ISR_LINE});
    rd_chk("overrun", ADDR_LSR, 8'h62);
    int_chk(1'b0);
    rx_head_err = 3'h4;
    int_chk(1'b1);
    rd_chk("break", ADDR_LSR, 8'h70);
    int_chk(1'b0);
    wr(ADDR_IER, 8'h00);
    pulse(1);
    int_chk(1'b0);
    wr(ADDR_IER, 8'h08);
    pulse(1);
    int_chk(1'b1);
    rd_chk("modem code", ADDR_ISR_FCR, {2'b11, ISR_MODEM});
    rd_chk("modem read", ADDR_MSR, 8'h00);
    int_chk(1'b0);
    wr(ADDR_IER, 8'h20);
    pulse(2);
    int_chk(1'b1);
    rd_chk("pause code", ADDR_ISR_FCR, {2'b11, ISR_XOFF});
    int_chk(1'b0);
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_IER, j ? 8'h80 : 8'h40);
      rd_chk("pin clear", ADDR_MSR, 8'h00);
      pin_n[j] = 1'b0;
      settle(4);
      int_chk(1'b0);
      pin_n[j] = 1'b1;
      settle(4);
      int_chk(1'b1);
      rd_chk("pin code", ADDR_ISR_FCR, {2'b11, ISR_FLOW});
    end
    complete_run;
  end
endmodule
`default_nettype wire
